/* shared/bmc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the bus master config block
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define BMC_ADDR_W 8
`define BMC_OFS_CONFIG 8'h00
`define BMC_OFS_STATUS 8'h04
`define BMC_OFS_DESC_BASE 8'h08

// ------------------------------------------------------------
// Config register fields
// ------------------------------------------------------------
`define BMC_SWR_BIT 0
`define BMC_ARB_BIT 1
`define BMC_GAP_LSB 2
`define BMC_GAP_MSB 6
`define BMC_BBE_BIT 7
`define BMC_BL_LSB 8
`define BMC_BL_MSB 13
`define BMC_CA_LSB 14
`define BMC_CA_MSB 15
`define BMC_RW_MASK 32'h0000fffe
`define BMC_GAP_RESET 5'h04

// ------------------------------------------------------------
// Burst length codes and limits
// ------------------------------------------------------------
`define BMC_BL_CA 6'h00
`define BMC_BL_1 6'h01
`define BMC_BL_2 6'h02
`define BMC_BL_4 6'h04
`define BMC_BL_8 6'h08
`define BMC_BL_16 6'h10
`define BMC_BL_32 6'h20
`define BMC_CA_8 2'h1
`define BMC_CA_16 2'h2
`define BMC_CA_32 2'h3
`define BMC_LEN_0 6'h00
`define BMC_LEN_1 6'h01
`define BMC_LEN_2 6'h02
`define BMC_LEN_4 6'h04
`define BMC_LEN_8 6'h08
`define BMC_LEN_16 6'h10
`define BMC_LEN_32 6'h20

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BMC_SWR_NS 200
`define BMC_CLK_NS 50
`define BMC_SWR_CYCLES 3'h4
`define BMC_ONE_CNT 3'h1
`define BMC_ONE_LEN 6'h01

`endif

/* shared/bmc_pkg.sv */
// Types shared by the bus master config block
package bmc_pkg;
    // Soft reset sequencer states
    typedef enum logic [1:0] {
        BMC_IDLE,
        BMC_RESET
    } bmc_rst_state_t;

    // Arbiter grant owner
    typedef enum logic [1:0] {
        BMC_GNT_NONE,
        BMC_GNT_RX,
        BMC_GNT_TX
    } bmc_grant_t;
endpackage : bmc_pkg

/* core/bmc_arbiter.sv */
// Internal bus arbiter between the transmit and receive DMA processes
`timescale 1ns/1ns
`include "bmc_defs.svh"

module bmc_arbiter (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    // Mode
    input wire logic tx_rx_priority_select_i,
    // Requests
    input wire logic rx_req_i,
    input wire logic tx_req_i,
    input wire logic bus_done_i,
    // Grant
    output bmc_pkg::bmc_grant_t grant_o
);
    import bmc_pkg::*;

    bmc_grant_t grant_reg; // Current owner of the internal bus
    logic last_rx_reg; // Rx held the bus last, used for fair turns

    assign grant_o = grant_reg;

    // ------------------------------------------------------------
    // Grant selection
    // ------------------------------------------------------------
    // A grant holds until the owner signals done, so a burst is never split
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            grant_reg <= BMC_GNT_NONE;
        end else if (soft_rst_i) begin
            grant_reg <= BMC_GNT_NONE;
        end else if (grant_reg == BMC_GNT_NONE || bus_done_i) begin
            if (rx_req_i && tx_req_i) begin
                if (tx_rx_priority_select_i) begin
                    // Equal priority: alternate turns
                    grant_reg <= last_rx_reg ? BMC_GNT_TX : BMC_GNT_RX;
                end else begin
                    // Receive always wins, it cannot be throttled by the wire
                    grant_reg <= BMC_GNT_RX;
                end
            end else if (rx_req_i) begin
                grant_reg <= BMC_GNT_RX;
            end else if (tx_req_i) begin
                grant_reg <= BMC_GNT_TX;
            end else begin
                grant_reg <= BMC_GNT_NONE;
            end
        end
    end

    // Remember who had the bus last
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            last_rx_reg <= 1'b0;
        end else if (grant_reg == BMC_GNT_RX) begin
            last_rx_reg <= 1'b1;
        end else if (grant_reg == BMC_GNT_TX) begin
            last_rx_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_rx_fixed_priority: assert property (@(posedge clock_i) disable iff (rst_i || soft_rst_i)
        (grant_reg == BMC_GNT_NONE && rx_req_i && tx_req_i && !tx_rx_priority_select_i)
        |=> grant_reg == BMC_GNT_RX)
        else $error("Receive not favoured under fixed priority");
    a_fair_turns: assert property (@(posedge clock_i) disable iff (rst_i || soft_rst_i)
        (bus_done_i && grant_reg == BMC_GNT_RX && rx_req_i && tx_req_i && tx_rx_priority_select_i)
        |=> grant_reg == BMC_GNT_TX)
        else $error("Equal priority did not hand over to transmit");
endmodule : bmc_arbiter

/* core/bmc_burst_limit.sv */
// Burst length limit decoder from the burst length and boundary fields
`timescale 1ns/1ns
`include "bmc_defs.svh"

module bmc_burst_limit (
    // Fields
    input wire logic [5:0] burst_length_field_i,
    input wire logic [1:0] burst_boundary_select_i,
    // Result
    output logic [5:0] max_words_o,
    output logic code_bad_o
);
    import bmc_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Reserved codes give zero, which stops the engine rather than guessing a size
    always_comb begin
        code_bad_o = 1'b0;
        unique case (burst_length_field_i)
            `BMC_BL_1: max_words_o = `BMC_LEN_1;
            `BMC_BL_2: max_words_o = `BMC_LEN_2;
            `BMC_BL_4: max_words_o = `BMC_LEN_4;
            `BMC_BL_8: max_words_o = `BMC_LEN_8;
            `BMC_BL_16: max_words_o = `BMC_LEN_16;
            `BMC_BL_32: max_words_o = `BMC_LEN_32;
            `BMC_BL_CA: begin
                // Defer to the boundary setting
                unique case (burst_boundary_select_i)
                    `BMC_CA_8: max_words_o = `BMC_LEN_8;
                    `BMC_CA_16: max_words_o = `BMC_LEN_16;
                    `BMC_CA_32: max_words_o = `BMC_LEN_32;
                    default: begin
                        max_words_o = `BMC_LEN_0;
                        code_bad_o = 1'b1;
                    end
                endcase
            end
            default: begin
                max_words_o = `BMC_LEN_0;
                code_bad_o = 1'b1;
            end
        endcase
    end
endmodule : bmc_burst_limit

/* core/bmc_ctrl.sv */
// Bus master configuration register, soft reset sequencer and DMA burst control
`timescale 1ns/1ns
`include "bmc_defs.svh"

module bmc_ctrl (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port
    input wire logic [`BMC_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Target access handshake
    input wire logic target_access_i,
    output logic target_ready_o,
    // DMA requests
    input wire logic rx_req_i,
    input wire logic tx_req_i,
    input wire logic [31:0] dma_word_i,
    input wire logic desc_advance_i,
    input wire logic [31:0] desc_start_i,
    // DMA side outputs
    output logic rx_grant_o,
    output logic tx_grant_o,
    output logic word_valid_o,
    output logic [31:0] dma_word_o,
    output logic burst_last_o,
    output logic [31:0] next_desc_addr_o,
    output logic soft_reset_o
);
    import bmc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] config_reg; // Writable config bits, reset bit kept apart
    logic soft_reset_bit_reg; // Self-clearing reset request, readable
    bmc_rst_state_t rst_state_reg; // Soft reset sequencer
    logic [2:0] rst_cnt_reg; // Cycles spent in soft reset
    logic [31:0] desc_base_reg; // Descriptor base, spared by soft reset
    logic [5:0] word_cnt_reg; // Words moved in current burst
    logic [31:0] rdata_reg; // Read data, stands one cycle
    logic target_ready_reg; // Target ready to the host side
    logic word_valid_reg; // Data word to memory valid
    logic [31:0] dma_word_reg; // Data word after byte order
    logic burst_last_reg; // Final word of a burst
    logic [31:0] next_desc_reg; // Next descriptor address
    logic grant_rx_reg; // Registered receive grant
    logic grant_tx_reg; // Registered transmit grant
    logic burst_done_reg; // Pulse when a burst ends
    logic soft_rst_active; // Soft reset sequence running
    logic [5:0] max_words; // Decoded burst word limit
    logic code_bad; // Reserved burst code selected
    bmc_grant_t grant; // Arbiter grant
    logic cfg_wr; // Write to the config register
    logic moving; // A word moves this cycle

    assign soft_rst_active = (rst_state_reg == BMC_RESET);
    assign cfg_wr = reg_wr_i && (reg_addr_i == `BMC_OFS_CONFIG);
    assign moving = (grant != BMC_GNT_NONE) && !code_bad && !soft_rst_active &&
                    ((grant == BMC_GNT_RX) ? rx_req_i : tx_req_i);

    // Swap bytes of a long word for big endian buffers
    function automatic logic [31:0] bmc_swap(input logic [31:0] w, input logic big);
        bmc_swap = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction : bmc_swap

    // Config value after either reset: only the gap field is nonzero
    function automatic logic [31:0] bmc_cfg_reset();
        bmc_cfg_reset = {16'h0000, 8'h00, 1'b0, `BMC_GAP_RESET, 2'h0};
    endfunction : bmc_cfg_reset

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    bmc_burst_limit u_limit (
        .burst_length_field_i(config_reg[`BMC_BL_MSB:`BMC_BL_LSB]),
        .burst_boundary_select_i(config_reg[`BMC_CA_MSB:`BMC_CA_LSB]),
        .max_words_o(max_words),
        .code_bad_o(code_bad)
    );

    bmc_arbiter u_arb (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .soft_rst_i(soft_rst_active),
        .tx_rx_priority_select_i(config_reg[`BMC_ARB_BIT]),
        .rx_req_i(rx_req_i),
        .tx_req_i(tx_req_i),
        .bus_done_i(burst_done_reg),
        .grant_o(grant)
    );

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    // Writes during soft reset are not taken; the target stalls them anyway
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            config_reg <= bmc_cfg_reset();
        end else if (soft_rst_active) begin
            config_reg <= bmc_cfg_reset();
        end else if (cfg_wr) begin
            // Reserved bits are masked off and read zero
            config_reg <= reg_wdata_i & `BMC_RW_MASK;
        end
    end

    // Descriptor base survives soft reset like the address registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            desc_base_reg <= 32'h0000_0000;
        end else if (reg_wr_i && reg_addr_i == `BMC_OFS_DESC_BASE && !soft_rst_active) begin
            desc_base_reg <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Soft reset sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rst_state_reg <= BMC_IDLE;
            rst_cnt_reg <= 3'h0;
            soft_reset_bit_reg <= 1'b0;
        end else begin
            unique case (rst_state_reg)
                BMC_IDLE: begin
                    // Arm on a write of one to the reset bit
                    if (cfg_wr && reg_wdata_i[`BMC_SWR_BIT]) begin
                        rst_state_reg <= BMC_RESET;
                        rst_cnt_reg <= `BMC_ONE_CNT;
                        soft_reset_bit_reg <= 1'b1;
                    end
                end
                BMC_RESET: begin
                    // Fourth cycle: release and clear the bit
                    if (rst_cnt_reg == `BMC_SWR_CYCLES) begin
                        rst_state_reg <= BMC_IDLE;
                        rst_cnt_reg <= 3'h0;
                        soft_reset_bit_reg <= 1'b0;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg + `BMC_ONE_CNT;
                    end
                end
            endcase
        end
    end

    // Target ready is withheld for every reset cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            target_ready_reg <= 1'b0;
        end else begin
            target_ready_reg <= target_access_i && !soft_rst_active &&
                                !(cfg_wr && reg_wdata_i[`BMC_SWR_BIT]);
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Unmapped addresses read zero; reserved config bits read zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            // The reset bit lives apart from the stored fields
            unique case (reg_addr_i)
                `BMC_OFS_CONFIG: rdata_reg <= config_reg | {31'h0, soft_reset_bit_reg};
                `BMC_OFS_STATUS: rdata_reg <= {16'h0000, 1'b0, code_bad, grant, 6'h00, word_cnt_reg};
                `BMC_OFS_DESC_BASE: rdata_reg <= desc_base_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    // Counts words and ends the burst at the decoded limit
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            word_cnt_reg <= 6'h00;
            burst_last_reg <= 1'b0;
            burst_done_reg <= 1'b0;
        end else if (soft_rst_active) begin
            word_cnt_reg <= 6'h00;
            burst_last_reg <= 1'b0;
            burst_done_reg <= 1'b0;
        end else if (burst_done_reg) begin
            // One idle cycle lets the arbiter switch owner
            word_cnt_reg <= 6'h00;
            burst_last_reg <= 1'b0;
            burst_done_reg <= 1'b0;
        end else if (moving) begin
            // Limit reached: close the burst
            if (word_cnt_reg + `BMC_ONE_LEN >= max_words) begin
                word_cnt_reg <= 6'h00;
                burst_last_reg <= 1'b1;
                burst_done_reg <= 1'b1;
            end else begin
                word_cnt_reg <= word_cnt_reg + `BMC_ONE_LEN;
                burst_last_reg <= 1'b0;
            end
        end else begin
            burst_last_reg <= 1'b0;
        end
    end

    // Data word path with buffer byte order
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            word_valid_reg <= 1'b0;
            dma_word_reg <= 32'h0000_0000;
        end else begin
            // Loaded every cycle, swapped only when big endian is set; valid marks the real words
            word_valid_reg <= moving && !burst_done_reg;
            dma_word_reg <= bmc_swap(dma_word_i, config_reg[`BMC_BBE_BIT]);
        end
    end

    // Grants registered for the DMA engines
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            grant_rx_reg <= 1'b0;
            grant_tx_reg <= 1'b0;
        end else begin
            // One cycle behind the arbiter
            grant_rx_reg <= (grant == BMC_GNT_RX);
            grant_tx_reg <= (grant == BMC_GNT_TX);
        end
    end

    // ------------------------------------------------------------
    // Descriptor chaining
    // ------------------------------------------------------------
    // Gap is in long words, so shift by two for a byte address
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            next_desc_reg <= 32'h0000_0000;
        end else if (soft_rst_active) begin
            // Soft reset drops the computed address
            next_desc_reg <= 32'h0000_0000;
        end else if (desc_advance_i) begin
            next_desc_reg <= desc_start_i + {25'h0, config_reg[`BMC_GAP_MSB:`BMC_GAP_LSB], 2'h0};
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = rdata_reg;
    assign target_ready_o = target_ready_reg;
    assign rx_grant_o = grant_rx_reg;
    assign tx_grant_o = grant_tx_reg;
    assign word_valid_o = word_valid_reg;
    assign dma_word_o = dma_word_reg;
    assign burst_last_o = burst_last_reg;
    assign next_desc_addr_o = next_desc_reg;
    assign soft_reset_o = soft_reset_bit_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Trigger: a write of one to the reset bit while idle
    sequence s_swr_write;
        cfg_wr && reg_wdata_i[`BMC_SWR_BIT] && !soft_rst_active;
    endsequence

    // The bit stands four cycles and then drops by itself
    sequence s_swr_hold;
        soft_reset_bit_reg [*4] ##1 !soft_reset_bit_reg;
    endsequence

    // Reset length, counted from the triggering write
    a_swr_four_clocks: assert property (@(posedge clock_i) disable iff (rst_i)
        s_swr_write |=> s_swr_hold)
        else $error("Soft reset did not last four clocks");

    // Self clearing, seen from the rise of the bit
    a_swr_self_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(soft_reset_bit_reg) |-> ##4 !soft_reset_bit_reg)
        else $error("Soft reset bit did not clear itself");

    // No target ready while the sequence runs
    a_trdy_held: assert property (@(posedge clock_i) disable iff (rst_i)
        soft_rst_active |=> !target_ready_reg)
        else $error("Target ready during soft reset");

    // Gap is back at its reset value when the bit drops
    a_gap_reset: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(soft_reset_bit_reg) |-> config_reg[`BMC_GAP_MSB:`BMC_GAP_LSB] == `BMC_GAP_RESET)
        else $error("Gap not four after soft reset");

    // The count stays below the limit while words move
    a_burst_bound: assert property (@(posedge clock_i) disable iff (rst_i)
        moving |-> word_cnt_reg < max_words)
        else $error("Burst exceeded limit");

    // Next descriptor is start plus gap, in bytes
    a_desc_next: assert property (@(posedge clock_i) disable iff (rst_i)
        (desc_advance_i && !soft_rst_active && !cfg_wr) |=>
        next_desc_reg == $past(desc_start_i) + {25'h0, config_reg[`BMC_GAP_MSB:`BMC_GAP_LSB], 2'h0})
        else $error("Next descriptor address wrong");

    // Big endian puts the top byte at the bottom
    a_byte_order: assert property (@(posedge clock_i) disable iff (rst_i)
        (config_reg[`BMC_BBE_BIT] && !cfg_wr && !soft_rst_active) |=>
        dma_word_reg[7:0] == $past(dma_word_i[31:24]))
        else $error("Big endian swap missing");

    // Soft reset spares the descriptor base
    a_base_kept: assert property (@(posedge clock_i) disable iff (rst_i)
        soft_rst_active |=> desc_base_reg == $past(desc_base_reg))
        else $error("Descriptor base changed by soft reset");

    // Nothing moves while the burst code is reserved
    a_reserved_idle: assert property (@(posedge clock_i) disable iff (rst_i)
        code_bad |=> !word_valid_reg)
        else $error("Word moved under a reserved burst code");

    // The closing word of a burst is a real word
    a_last_has_word: assert property (@(posedge clock_i) disable iff (rst_i)
        burst_last_reg |-> word_valid_reg)
        else $error("Burst end flagged without a word");
endmodule : bmc_ctrl

/* tb/bmc_host_mem.sv */
// Behavioural host memory model feeding DMA words and descriptor addresses
`timescale 1ns/1ns
module bmc_host_mem (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Memory side
    output logic [31:0] word_o,
    output logic [31:0] desc_start_o
);
    // --------------------------------------------
    // Data words
    // --------------------------------------------
    // New word every cycle, so a stale or stuck data path shows up
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            word_o <= 32'h1234abcd;
        end else begin
            word_o <= {word_o[30:0], word_o[31] ^ word_o[21] ^ word_o[1] ^ word_o[0]};
        end
    end
    // Descriptor start moves each cycle; it stays long word aligned
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            desc_start_o <= 32'h00001000;
        end else begin
            desc_start_o <= desc_start_o + 32'h00000044;
        end
    end
endmodule : bmc_host_mem

/* tb/bus_master_config_ctrl_test.sv */
// Self-checking testbench of the bus master config block
`timescale 1ns/1ns
`include "bmc_defs.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module bus_master_config_ctrl_test;
    logic clock_i = 1'b0; // Bench clock
    logic rst_i = 1'b1; // Hardware reset
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic target_access_i = 1'b1; // Host keeps probing the target
    logic rx_req_i = 1'b0;
    logic tx_req_i = 1'b0;
    logic desc_advance_i = 1'b0;
    logic [31:0] dma_word_i, desc_start_i, reg_rdata_o, dma_word_o, next_desc_addr_o, r;
    logic target_ready_o, rx_grant_o, tx_grant_o, word_valid_o, burst_last_o, soft_reset_o;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;
    // --------------------------------------------
    // Design and far side
    // --------------------------------------------
    bmc_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .target_access_i(target_access_i),
        .target_ready_o(target_ready_o), .rx_req_i(rx_req_i), .tx_req_i(tx_req_i), .dma_word_i(dma_word_i),
        .desc_advance_i(desc_advance_i), .desc_start_i(desc_start_i), .rx_grant_o(rx_grant_o),
        .tx_grant_o(tx_grant_o), .word_valid_o(word_valid_o), .dma_word_o(dma_word_o),
        .burst_last_o(burst_last_o), .next_desc_addr_o(next_desc_addr_o), .soft_reset_o(soft_reset_o));
    bmc_host_mem u_mem (.clock_i(clock_i), .rst_i(rst_i), .word_o(dma_word_i), .desc_start_o(desc_start_i));
    // 20 MHz clock
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    // Hang guard, well above the few hundred cycles the tests take
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // --------------------------------------------
    // Expectations and bus tasks
    // --------------------------------------------
    function automatic logic [31:0] swap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap
    // Words allowed per burst; zero code borrows the boundary size
    function automatic int blen(input logic [5:0] bl, input logic [1:0] ca);
        if (bl inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20}) return int'(bl);
        if (bl == 6'h00 && ca != 2'h0) return 4 << ca;
        return 0;
    endfunction : blen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i) begin reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; end
        @(posedge clock_i) reg_wr_i <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i) begin reg_addr_i <= a; reg_rd_i <= 1'b1; end
        @(posedge clock_i) reg_rd_i <= 1'b0;
        @(negedge clock_i) d = reg_rdata_o;
    endtask : rd
    // Requests are dropped before every config write, as software must
    task automatic burst(input logic [5:0] bl, input logic [1:0] ca);
        int n, k;
        n = 0;
        wr(8'h00, {16'h0, ca, bl, 8'h10});
        @(posedge clock_i) rx_req_i <= 1'b1;
        for (k = 0; k < 90 && burst_last_o !== 1'b1; k++) begin
            @(negedge clock_i);
            if (word_valid_o === 1'b1) n++;
        end
        @(posedge clock_i) rx_req_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        `CHK("burst words", blen(bl, ca), n)
    endtask : burst
    task automatic tx_rx_priority_select(input logic eq);
        int t, u;
        t = 0;
        u = 0;
        wr(8'h00, {16'h0, 2'h1, 6'h01, 6'h04, eq, 1'b0});
        @(posedge clock_i) begin rx_req_i <= 1'b1; tx_req_i <= 1'b1; end
        repeat (30) begin @(negedge clock_i); if (tx_grant_o === 1'b1) t++; if (rx_grant_o === 1'b1) u++; end
        @(posedge clock_i) begin rx_req_i <= 1'b0; tx_req_i <= 1'b0; end
        repeat (4) @(posedge clock_i);
        `CHK("tx served", eq, t > 0)
        `CHK("rx served", 1'b1, u > 0)
    endtask : tx_rx_priority_select
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // --------------------------------------------
    // Main sequence
    // --------------------------------------------
    initial begin
        int n, bad;
        logic [4:0] g;
        void'($urandom(32'h8aa1));
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(8'h00, r);
        `CHK("config reset", 32'h00000010, r)
        rd(8'h40, r);
        `CHK("unmapped", 32'h0, r)
        $display("test reset done");
        // Random field values read back, soft reset bit kept clear
        repeat (6) begin
            n = int'($urandom & `BMC_RW_MASK);
            wr(8'h00, 32'(n));
            rd(8'h00, r);
            `CHK("config rw", 32'(n), r)
        end
        for (i = 0; i < 2; i++) begin
            wr(8'h00, {24'h0, i[0], 7'h10});
            repeat (4) begin
                @(negedge clock_i) r = dma_word_i;
                @(negedge clock_i) `CHK("byte order", i[0] ? swap(r) : r, dma_word_o)
            end
        end
        $display("test config done");
        // Gap corners zero and 31 then random
        for (i = 0; i < 4; i++) begin
            g = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
            wr(8'h00, {24'h0, 1'b0, g, 2'b00});
            @(posedge clock_i) desc_advance_i <= 1'b1;
            @(negedge clock_i) r = desc_start_i;
            @(posedge clock_i) desc_advance_i <= 1'b0;
            @(negedge clock_i) `CHK("next desc", r + {25'h0, g, 2'b00}, next_desc_addr_o)
        end
        $display("test descriptor done");
        for (i = 0; i < 10; i++) burst((i < 6) ? 6'(1 << i) : 6'h00, (i < 6) ? 2'h1 : 2'(i - 6));
        burst(6'h03, 2'h1);
        rd(8'h04, r);
        `CHK("bad code", 1'b1, r[14])
        tx_rx_priority_select(1'b0);
        tx_rx_priority_select(1'b1);
        $display("test dma done");
        // Soft reset with target probed all along; descriptor base survives
        n = 0;
        bad = 0;
        wr(8'h08, 32'h0000a5a0);
        wr(8'h00, 32'h0000e3a3);
        repeat (8) begin
            @(negedge clock_i);
            if (soft_reset_o === 1'b1) n++;
            if (soft_reset_o === 1'b1 && target_ready_o !== 1'b0) bad++;
        end
        `CHK("reset cycles", 4, n)
        `CHK("ready held", 0, bad)
        `CHK("ready back", 1'b1, target_ready_o)
        rd(8'h00, r);
        `CHK("config after", 32'h00000010, r)
        rd(8'h08, r);
        `CHK("base kept", 32'h0000a5a0, r)
        $display("test soft reset done");
        give_verdict();
    end
endmodule : bus_master_config_ctrl_test
